// ===== core/fsc_config_decoder.sv
`timescale 1ns/100ps
module fsc_config_decoder
  import fsc_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  addr_tens,
  input  wire logic [3:0]  addr_units,
  input  wire logic        remote_io_mode,
  input  wire logic        offline_hold_select,
  input  wire logic        spare_function_switch,
  input  wire logic        rate_select_low,
  input  wire logic        rate_select_high,
  input  wire logic        slave_offline,
  input  wire logic        conn_req,
  input  wire logic [1:0]  conn_type,
  output logic      [5:0]  node_address,
  output logic             address_valid,
  output logic             config_ready,
  output logic             config_error,
  output logic             network_enable,
  output logic             remote_io_active,
  output logic             extended_rate,
  output logic      [2:0]  baud_rate_code,
  output logic      [10:0] baud_kbps,
  output logic             io_buffer_hold,
  output logic             io_buffer_clear,
  output logic             conn_grant,
  output logic             conn_reject,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Power-up switch capture
  // ----------------------------------------------------------------
  localparam int SW_W = 12;

  // Spare switch deliberately left out of the captured vector
  wire [SW_W-1:0] sw_live = {remote_io_mode, offline_hold_select, rate_select_high,
                             rate_select_low, addr_tens, addr_units};
  logic [SW_W-1:0] sw_held;
  logic            held_valid;
  logic            held_pulse;

  fsc_switch_latch #(
    .W      (SW_W),
    .SETTLE (SETTLE)
  ) u_latch (
    .pclk       (pclk),
    .presetn    (presetn),
    .sw_live    (sw_live),
    .sw_held    (sw_held),
    .held_valid (held_valid),
    .held_pulse (held_pulse)
  );

  // ----------------------------------------------------------------
  // Decode of the captured switches
  // ----------------------------------------------------------------
  wire [3:0] held_units = sw_held[3:0];
  wire [3:0] held_tens  = sw_held[7:4];
  wire       held_low   = sw_held[8];
  wire       held_high  = sw_held[9];
  wire       held_hold  = sw_held[10];
  wire       held_rio   = sw_held[11];

  wire [6:0] addr_sum    = fsc_bcd_addr(held_tens, held_units);
  wire       digits_ok   = (held_tens <= DIGIT_MAX) && (held_units <= DIGIT_MAX);
  wire       addr_ok     = digits_ok && (addr_sum <= NODE_ADDR_MAX);
  wire       ext_mode    = held_low && held_high;
  logic [2:0] rate_ext;
  wire [2:0] std_rate    = held_high ? RATE_500K : (held_low ? RATE_250K : RATE_125K);
  wire [2:0] rate_sel    = ext_mode ? rate_ext : std_rate;
  wire       online      = held_valid && addr_ok;
  wire       conn_legal  = (conn_type == CONN_POLL) || (conn_type == CONN_EXPLICIT);

  // Live view differs from the frozen copy: report, but never apply
  wire       sw_moved    = held_valid && (sw_live != sw_held);
  logic      sw_moved_q;
  logic      offline_q;
  wire       offline_rise = slave_offline && !offline_q;

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      node_address     <= 6'h00;
      address_valid    <= 1'b0;
      config_ready     <= 1'b0;
      config_error     <= 1'b0;
      network_enable   <= 1'b0;
      remote_io_active <= 1'b0;
      extended_rate    <= 1'b0;
      baud_rate_code   <= RATE_125K;
      baud_kbps        <= 11'd125;
    end else begin
      node_address     <= addr_sum[5:0];
      address_valid    <= held_valid && addr_ok;
      config_ready     <= held_valid;
      config_error     <= held_valid && !addr_ok;
      network_enable   <= online;
      remote_io_active <= held_valid && held_rio;
      extended_rate    <= held_valid && ext_mode;
      baud_rate_code   <= rate_sel;
      baud_kbps        <= fsc_rate_kbps(rate_sel);
    end
  end

  // ----------------------------------------------------------------
  // Offline buffer policy and connection filter
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offline_q       <= 1'b0;
      io_buffer_hold  <= 1'b0;
      io_buffer_clear <= 1'b0;
      conn_grant      <= 1'b0;
      conn_reject     <= 1'b0;
      sw_moved_q      <= 1'b0;
    end else begin
      offline_q       <= slave_offline;
      sw_moved_q      <= sw_moved;
      io_buffer_hold  <= online && slave_offline && held_hold;
      io_buffer_clear <= online && offline_rise && !held_hold;
      conn_grant      <= conn_req && online && conn_legal;
      conn_reject     <= conn_req && !(online && conn_legal);
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire setup     = psel && !penable;
  wire access    = psel && penable;
  wire hit_cfg   = (paddr == REG_CONFIG);
  wire hit_rate  = (paddr == REG_RATE_EXT);
  wire hit_stat  = (paddr == REG_IRQ_STATUS);
  wire hit_mask  = (paddr == REG_IRQ_MASK);
  wire hit_live  = (paddr == REG_LIVE_SW);
  wire mapped    = hit_cfg | hit_rate | hit_stat | hit_mask | hit_live;
  wire wr_rate   = access && pwrite && hit_rate;
  wire wr_mask   = access && pwrite && hit_mask;
  wire rd_stat   = access && !pwrite && hit_stat;

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;

  wire [IRQ_W-1:0] irq_events;
  assign irq_events[IRQ_DONE]        = held_pulse;
  assign irq_events[IRQ_ERROR]       = held_pulse && !addr_ok;
  assign irq_events[IRQ_OFFLINE]     = offline_rise && online;
  assign irq_events[IRQ_SW_MOVED]    = sw_moved && !sw_moved_q;
  assign irq_events[IRQ_CONN_REJECT] = conn_req && !(online && conn_legal);

  // Read clears only the bits it returned (snapshot taken at setup), so an
  // event landing between setup and access is kept; set also beats clear
  wire [IRQ_W-1:0] next_irq_status = (rd_stat ? (irq_status & ~prdata[IRQ_W-1:0]) : irq_status) | irq_events;

  // Rate register only steers the link in extended mode; it is
  // still writable at any time so software can prepare it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_ext   <= RATE_EXT_RESET;
      irq_mask   <= IRQ_MASK_RESET;
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
      if (wr_rate)
        rate_ext <= pwdata[2:0];
      if (wr_mask)
        irq_mask <= pwdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Read data, taken in the setup cycle
  // ----------------------------------------------------------------
  logic [31:0] cfg_word;
  always_comb begin
    cfg_word                                = 32'h0000_0000;
    cfg_word[CFG_ADDR_LSB +: 6]             = addr_sum[5:0];
    cfg_word[CFG_VALID_BIT]                 = held_valid && addr_ok;
    cfg_word[CFG_EXT_BIT]                   = ext_mode;
    cfg_word[CFG_HOLD_BIT]                  = held_hold;
    cfg_word[CFG_RIO_BIT]                   = held_rio;
    cfg_word[CFG_DONE_BIT]                  = held_valid;
    cfg_word[CFG_ONLINE_BIT]                = online;
    cfg_word[CFG_RATE_LSB +: 3]             = rate_sel;
  end

  wire [31:0] rd_mux =
      hit_cfg  ? cfg_word :
      hit_rate ? {29'h0, rate_ext} :
      hit_stat ? {{(32-IRQ_W){1'b0}}, irq_status} :
      hit_mask ? {{(32-IRQ_W){1'b0}}, irq_mask} :
      hit_live ? {19'h0, spare_function_switch, sw_live} :
                 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= rd_mux;
  end

endmodule : fsc_config_decoder

// ===== core/fsc_pkg.sv
package fsc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 8;
  localparam int SETTLE_TIME_NS = 1000;
  localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Address limits
  // ----------------------------------------------------------------
  localparam logic [6:0] NODE_ADDR_MAX = 7'd63;
  localparam logic [3:0] DIGIT_MAX     = 4'd9;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CONFIG     = 8'h00;
  localparam logic [7:0] REG_RATE_EXT   = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK   = 8'h0c;
  localparam logic [7:0] REG_LIVE_SW    = 8'h10;

  // Config register fields
  localparam int CFG_ADDR_LSB   = 0;
  localparam int CFG_VALID_BIT  = 8;
  localparam int CFG_EXT_BIT    = 9;
  localparam int CFG_HOLD_BIT   = 10;
  localparam int CFG_RIO_BIT    = 11;
  localparam int CFG_DONE_BIT   = 12;
  localparam int CFG_ONLINE_BIT = 13;
  localparam int CFG_RATE_LSB   = 16;

  // Interrupt bits
  localparam int IRQ_W           = 5;
  localparam int IRQ_DONE        = 0;
  localparam int IRQ_ERROR       = 1;
  localparam int IRQ_OFFLINE     = 2;
  localparam int IRQ_SW_MOVED    = 3;
  localparam int IRQ_CONN_REJECT = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RATE_10K   = 3'h0,
    RATE_20K   = 3'h1,
    RATE_50K   = 3'h2,
    RATE_125K  = 3'h3,
    RATE_250K  = 3'h4,
    RATE_500K  = 3'h5,
    RATE_800K  = 3'h6,
    RATE_1000K = 3'h7
  } fsc_rate_t;

  localparam logic [2:0] RATE_EXT_RESET = 3'h3;

  typedef enum logic [1:0] {
    CONN_EXPLICIT = 2'h0,
    CONN_POLL     = 2'h1,
    CONN_STROBE   = 2'h2,
    CONN_COS      = 2'h3
  } fsc_conn_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] fsc_rate_kbps(input logic [2:0] code);
    case (code)
      RATE_10K:   fsc_rate_kbps = 11'd10;
      RATE_20K:   fsc_rate_kbps = 11'd20;
      RATE_50K:   fsc_rate_kbps = 11'd50;
      RATE_125K:  fsc_rate_kbps = 11'd125;
      RATE_250K:  fsc_rate_kbps = 11'd250;
      RATE_500K:  fsc_rate_kbps = 11'd500;
      RATE_800K:  fsc_rate_kbps = 11'd800;
      default:    fsc_rate_kbps = 11'd1000;
    endcase
  endfunction : fsc_rate_kbps

  function automatic logic [6:0] fsc_bcd_addr(input logic [3:0] tens, input logic [3:0] units);
    fsc_bcd_addr = 7'((tens * 4'd10) + {3'h0, units});
  endfunction : fsc_bcd_addr

endpackage : fsc_pkg

// ===== core/fsc_switch_latch.sv
`timescale 1ns/100ps
module fsc_switch_latch
  import fsc_pkg::*;
#(
  parameter int W      = 12,
  parameter int SETTLE = SETTLE_CYCLES
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] sw_live,
  output logic      [W-1:0] sw_held,
  output logic              held_valid,
  output logic              held_pulse
);

  typedef enum logic [1:0] {
    ST_SETTLE  = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_LOCKED  = 2'b11
  } fsc_latch_st_t;

  localparam int CW = $clog2(SETTLE + 1);

  fsc_latch_st_t  state;
  fsc_latch_st_t  next_state;
  logic [CW-1:0]  count;
  logic [W-1:0]   sw_prev;

  wire moved   = (sw_live != sw_prev);
  wire settled = (count == CW'(SETTLE));

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Contacts bounce at power-up, so the count restarts on any change
  always_comb begin
    case (state)
      ST_SETTLE:  next_state = (settled && !moved) ? ST_CAPTURE : ST_SETTLE;
      ST_CAPTURE: next_state = ST_LOCKED;
      ST_LOCKED:  next_state = ST_LOCKED;
      default:    next_state = ST_SETTLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= ST_SETTLE;
      count   <= '0;
      sw_prev <= '0;
    end else begin
      state   <= next_state;
      sw_prev <= sw_live;
      if (moved)
        count <= '0;
      else if (!settled)
        count <= count + CW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Capture, once per reset
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_held    <= '0;
      held_valid <= 1'b0;
      held_pulse <= 1'b0;
    end else begin
      held_pulse <= (state == ST_CAPTURE);
      if (state == ST_CAPTURE) begin
        sw_held    <= sw_prev;
        held_valid <= 1'b1;
      end
    end
  end

endmodule : fsc_switch_latch

// ===== dv/fsc_props.sv
`timescale 1ns/100ps
module fsc_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        slave_offline,
  input wire logic        conn_req,
  input wire logic [1:0]  conn_type,
  input wire logic [5:0]  node_address,
  input wire logic        address_valid,
  input wire logic        config_ready,
  input wire logic        config_error,
  input wire logic        network_enable,
  input wire logic        remote_io_active,
  input wire logic        extended_rate,
  input wire logic [2:0]  baud_rate_code,
  input wire logic [10:0] baud_kbps,
  input wire logic        io_buffer_hold,
  input wire logic        io_buffer_clear,
  input wire logic        conn_grant,
  input wire logic        conn_reject
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_enable;
    network_enable == (config_ready && address_valid);
  endproperty
  a_enable: assert property (p_enable) else $error("network enable wrong");
  property p_error;
    config_error |-> config_ready && !address_valid && !network_enable;
  endproperty
  a_error: assert property (p_error) else $error("config error while usable");
  property p_frozen;
    config_ready && $past(config_ready) |-> $stable(node_address) && $stable(remote_io_active)
      && $stable(extended_rate) && (extended_rate || $stable(baud_rate_code));
  endproperty
  a_frozen: assert property (p_frozen) else $error("captured setting moved");
  property p_std_rate;
    config_ready && !extended_rate |-> baud_rate_code inside {3'h3, 3'h4, 3'h5};
  endproperty
  a_std_rate: assert property (p_std_rate) else $error("standard rate code wrong");
  property p_kbps;
    config_ready |-> (baud_rate_code != 3'h6 || baud_kbps == 11'd800)
      && (baud_rate_code != 3'h0 || baud_kbps == 11'd10);
  endproperty
  a_kbps: assert property (p_kbps) else $error("rate value wrong");
  property p_hold;
    io_buffer_hold |-> $past(slave_offline) && network_enable;
  endproperty
  a_hold: assert property (p_hold) else $error("hold without off-line slave");
  property p_clear;
    io_buffer_clear |-> $past(slave_offline) && !$past(slave_offline, 2) && !io_buffer_hold
      ##1 !io_buffer_clear;
  endproperty
  a_clear: assert property (p_clear) else $error("clear pulse wrong");
  property p_conn;
    conn_req |=> conn_grant ^ conn_reject;
  endproperty
  a_conn: assert property (p_conn) else $error("request not answered once");
  property p_grant;
    conn_grant |-> $past(conn_req) && ($past(conn_type) inside {2'h0, 2'h1}) && network_enable;
  endproperty
  a_grant: assert property (p_grant) else $error("grant of refused kind");
  c_err: cover property (config_error);
  c_ext: cover property (config_ready && extended_rate);
  c_clr: cover property (io_buffer_clear);
  c_rej: cover property (conn_reject);
endmodule : fsc_props

bind fsc_config_decoder fsc_props u_props (.pclk, .presetn, .slave_offline, .conn_req, .conn_type,
  .node_address, .address_valid, .config_ready, .config_error, .network_enable, .remote_io_active,
  .extended_rate, .baud_rate_code, .baud_kbps, .io_buffer_hold, .io_buffer_clear, .conn_grant,
  .conn_reject);

// ===== dv/fsc_peer.sv
`timescale 1ns/100ps
module fsc_peer (
  input  wire logic       pclk,
  output logic            slave_offline,
  output logic            conn_req,
  output logic      [1:0] conn_type
);
  initial begin
    slave_offline = 1'b0;
    conn_req      = 1'b0;
    conn_type     = 2'h0;
  end
  // Type is inverted when idle so a stale value is never mistaken
  task automatic request(input logic [1:0] t);
    @(posedge pclk);
    conn_req  <= 1'b1;
    conn_type <= t;
    @(posedge pclk);
    conn_req  <= 1'b0;
    conn_type <= ~t;
  endtask : request
  task automatic set_offline(input logic v);
    @(posedge pclk);
    slave_offline <= v;
  endtask : set_offline
endmodule : fsc_peer

// ===== dv/fieldbus_switch_config_decoder_test.sv
`timescale 1ns/100ps
module fieldbus_switch_config_decoder_test;
  import fsc_pkg::*;
  localparam int ST = 16;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  addr_tens, addr_units;
  logic        remote_io_mode, offline_hold_select, spare_function_switch;
  logic        rate_select_low, rate_select_high, slave_offline, conn_req;
  logic [1:0]  conn_type;
  logic [5:0]  node_address;
  logic        address_valid, config_ready, config_error, network_enable, remote_io_active;
  logic        extended_rate, io_buffer_hold, io_buffer_clear, conn_grant, conn_reject;
  logic [2:0]  baud_rate_code;
  logic [10:0] baud_kbps;
  int          mismatches, cmp_count, cyc;
  int          kt[8] = '{10, 20, 50, 125, 250, 500, 800, 1000};

  fsc_config_decoder #(.SETTLE(ST)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .addr_tens, .addr_units, .remote_io_mode, .offline_hold_select,
    .spare_function_switch, .rate_select_low, .rate_select_high, .slave_offline, .conn_req, .conn_type,
    .node_address, .address_valid, .config_ready, .config_error, .network_enable, .remote_io_active,
    .extended_rate, .baud_rate_code, .baud_kbps, .io_buffer_hold, .io_buffer_clear, .conn_grant,
    .conn_reject, .irq);
  fsc_peer peer (.pclk, .slave_offline, .conn_req, .conn_type);

  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // sw = {mode, hold, low, high, spare}
  task automatic run_cfg(input logic [3:0] t, input logic [3:0] u, input logic [4:0] sw,
                         input logic [2:0] re);
    logic [31:0] r;
    logic        e, v, x;
    logic [6:0]  a;
    logic [2:0]  rc;
    a  = 7'(int'(t) * 10 + int'(u));
    v  = (t <= 4'd9) && (u <= 4'd9) && (a <= 7'd63);
    x  = sw[2] & sw[1];
    rc = x ? re : sw[1] ? 3'h5 : sw[2] ? 3'h4 : 3'h3;
    @(posedge pclk);
    presetn    <= 1'b0;
    addr_tens  <= t;
    addr_units <= u;
    {remote_io_mode, offline_hold_select, rate_select_low, rate_select_high, spare_function_switch} <= sw;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_RATE_EXT, 32'h0, r, e);
    chk(r[2:0], RATE_EXT_RESET);
    apb(1'b1, REG_RATE_EXT, 32'(re), r, e);
    apb(1'b1, REG_IRQ_MASK, 32'h8, r, e);
    for (int i = 0; i < 100 && config_ready !== 1'b1; i++) @(posedge pclk);
    #1;
    chk(node_address, a[5:0]);
    chk({address_valid, config_error, network_enable, config_ready}, {v, !v, v, 1'b1});
    chk({remote_io_active, extended_rate, baud_rate_code}, {sw[4], x, rc});
    chk(baud_kbps, kt[rc]);
    apb(1'b0, REG_CONFIG, 32'h0, r, e);
    chk(r, {13'h0, rc, 2'b00, v, 1'b1, sw[4], sw[3], x, v, 2'b00, a[5:0]});
    apb(1'b0, REG_LIVE_SW, 32'h0, r, e);
    chk(r, {19'h0, sw[0], sw[4], sw[3], sw[1], sw[2], t, u});
    for (int k = 0; k < 4; k++) begin
      peer.request(2'(k));
      #1;
      chk({conn_grant, conn_reject}, {v && k < 2, !(v && k < 2)});
    end
    peer.set_offline(1'b1);
    @(posedge pclk);
    #1;
    chk({io_buffer_hold, io_buffer_clear}, {v & sw[3], v & !sw[3]});
    @(posedge pclk);
    #1;
    chk({io_buffer_hold, io_buffer_clear}, {v & sw[3], 1'b0});
    peer.set_offline(1'b0);
    // Moves after capture only flag an event
    addr_units <= ~u;
    {remote_io_mode, offline_hold_select, rate_select_low, rate_select_high, spare_function_switch} <= ~sw;
    repeat (4) @(posedge pclk);
    #1;
    chk({node_address, remote_io_active, baud_rate_code, address_valid}, {a[5:0], sw[4], rc, v});
    chk(irq, 1'b1);
    apb(1'b0, REG_IRQ_STATUS, 32'h0, r, e);
    chk(r[4:0], {1'b1, 1'b1, v, !v, 1'b1});
    #1;
    chk(irq, 1'b0);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk(32'(e), 32'h0000_0001);
    chk(r, 32'h0000_0000);
  endtask : run_cfg

  task automatic report_and_stop();
    $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {addr_tens, addr_units} = 8'h00;
    {remote_io_mode, offline_hold_select, rate_select_low, rate_select_high, spare_function_switch} = 5'h00;
    mismatches = 0;
    cmp_count = 0;
    cyc = 0;
    run_cfg(4'd2, 4'd6, 5'b01000, 3'h0);
    run_cfg(4'd6, 4'd3, 5'b10101, 3'h0);
    run_cfg(4'd6, 4'd4, 5'b01010, 3'h0);
    run_cfg(4'd9, 4'd9, 5'b10111, 3'h7);
    run_cfg(4'd0, 4'hc, 5'b00000, 3'h0);
    for (int n = 0; n < 8; n++) run_cfg(4'd0, 4'(n), {n[0], n[1], 2'b11, n[2]}, 3'(n));
    report_and_stop();
  end
endmodule : fieldbus_switch_config_decoder_test
